//--- verilog/msp_pkg.sv
// Constants and types of the MIDI serial port.
// Assumes one 100 MHz clock; slower rates derive from it.
package msp_pkg;

    // ==================================================================
    // Register map (selected by address bit zero only)
    localparam logic ADDR_CTRL = 1'b0;
    localparam logic ADDR_DATA = 1'b1;

    // ==================================================================
    // Command register fields
    localparam int CMD_RATE_LO = 0;
    localparam int CMD_RATE_HI = 1;
    localparam int CMD_TXC_LO = 5;
    localparam int CMD_TXC_HI = 6;
    localparam int CMD_RIE = 7;
    localparam logic [7:0] CMD_RESET_VAL = 8'h03;

    // ==================================================================
    // Status register fields
    localparam int ST_RBF = 0;
    localparam int ST_TBE = 1;
    localparam int ST_CTS = 3;
    localparam int ST_FE = 4;
    localparam int ST_OV = 5;
    localparam int ST_IRQ = 7;

    typedef enum logic [1:0] {
        RATE_SLOW = 2'b00,
        RATE_MIDI = 2'b01,
        RATE_FAST = 2'b10,
        RATE_RESET = 2'b11
    } msp_rate_t;

    typedef enum logic [1:0] {
        TXC_RTS_NOIRQ = 2'b00,
        TXC_RTS_IRQ = 2'b01,
        TXC_NORTS = 2'b10,
        TXC_BREAK = 2'b11
    } msp_txc_t;

    // ==================================================================
    // Timing: bit rates in Hz and 16x oversampling divisors
    localparam int CLK_HZ = 100_000_000;
    localparam int RATE_SLOW_HZ = 9600;
    localparam int RATE_MIDI_HZ = 31250;
    localparam int RATE_FAST_HZ = 38400;
    localparam int OVS = 16;
    localparam int DIV_W = 10;
    localparam logic [DIV_W-1:0] DIV_SLOW = DIV_W'(CLK_HZ / (RATE_SLOW_HZ * OVS));
    localparam logic [DIV_W-1:0] DIV_MIDI = DIV_W'(CLK_HZ / (RATE_MIDI_HZ * OVS));
    localparam logic [DIV_W-1:0] DIV_FAST = DIV_W'(CLK_HZ / (RATE_FAST_HZ * OVS));
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [2:0] DATA_LAST = 3'h7;
    localparam logic [3:0] TX_FRAME_BITS = 4'ha;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } msp_rx_st_t;

    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_SHIFT = 1'b1
    } msp_tx_st_t;

endpackage

//--- verilog/msp_strm_if.sv
// Byte stream carrier with valid/ready between the port's own modules.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface msp_strm_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- verilog/msp_fifo2.sv
// Two-entry buffer on the transmit path.
// Assumes same-clock producer and consumer; full and empty are exact.
`timescale 1ns/1ps
module msp_fifo2 (
    input wire logic clock,
    input wire logic rstn,
    input wire logic flush,
    msp_strm_if.snk in_s,
    msp_strm_if.src out_s
);
    logic [7:0] mem_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    // ==================================================================
    // Handshake
    assign in_s.ready = (count_q != 2'd2);
    assign out_s.valid = (count_q != 2'd0);
    assign out_s.data = mem_q[rd_ptr_q];
    assign push = in_s.valid & in_s.ready;
    assign pop = out_s.valid & out_s.ready;

    // Storage; entries are plain flops so the read side is a register mux
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
        end else if (push) begin
            mem_q[wr_ptr_q] <= in_s.data;
        end
    end

    // Pointers and fill level; flush drops any queued bytes
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'd0;
        end else if (flush) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'd0;
        end else begin
            if (push) wr_ptr_q <= ~wr_ptr_q;
            if (pop) rd_ptr_q <= ~rd_ptr_q;
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

//--- verilog/msp_baud.sv
// Oversampling tick generator for the serial port.
// Assumes the 100 MHz clock; gives one-cycle pulses at 16x the bit rate.
`timescale 1ns/1ps
module msp_baud (
    input wire logic clock,
    input wire logic rstn,
    input msp_pkg::msp_rate_t rate,
    output logic tick
);
    import msp_pkg::*;

    logic [DIV_W-1:0] cnt_q;

    // Rate code to divisor; the reset code has no rate
    function automatic logic [DIV_W-1:0] rate_div(input msp_rate_t r);
        case (r)
            RATE_SLOW: rate_div = DIV_SLOW;
            RATE_MIDI: rate_div = DIV_MIDI;
            RATE_FAST: rate_div = DIV_FAST;
            default: rate_div = DIV_SLOW;
        endcase
    endfunction

    // ==================================================================
    // Down counter; parked while the port is held in reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (rate == RATE_RESET) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (cnt_q == '0) begin
            cnt_q <= rate_div(rate) - DIV_W'(1);
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q - DIV_W'(1);
            tick <= 1'b0;
        end
    end
endmodule

//--- verilog/msp_serial_port.sv
// MIDI serial port: host registers, transmitter, receiver and interrupt.
// Assumes host strobes and serial pins are asynchronous; all are synchronised.
//
// How it works
// - Select low: address bit zero picks status/command (0) or data (1).
// - Bit-rate field resets to 11 on master reset.
// - Rate code 11 holds the port in reset until a valid rate is written.
// - Command bits 6:5 steer transmit interrupt, request-to-send and break.
// - Command bit 7 enables interrupt on receive full or overrun.
// - Status bit 0 sets on received character, clears on data read.
// - Status bit 1 clears on data write, sets once shifter takes it.
// - Status bit 3 mirrors the clear-to-send pin level.
// - Clear-to-send high forces transmit-empty status to zero.
// - Status bit 4 flags a missing stop bit, kept with the character.
// - Status bit 5 sets on unread overwrite, clears on data read.
// - Status bit 7 shows the pending interrupt request.
// - Data writes load transmit buffer; data reads return receive buffer.
// - Rate codes 00, 01, 10 give 9.6, 31.25, 38.4 kHz.
`timescale 1ns/1ps
module msp_serial_port (
    input wire logic clock,
    input wire logic rstn,
    input wire logic serial_port_select_n,
    input wire logic host_addr0,
    input wire logic host_read_n,
    input wire logic host_write_n,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe_n,
    output logic irq_n,
    input wire logic clear_to_send_n,
    output logic request_to_send_n,
    input wire logic serial_rx,
    output logic serial_tx
);
    import msp_pkg::*;

    // ==================================================================
    // Pin synchronisers
    localparam int SYNC_W = 14;
    logic [SYNC_W-1:0] pins_raw, sync1_q, sync2_q;
    logic cs_n_s, a0_s, rd_n_s, wr_n_s, cts_n_s, rx_s;
    logic [7:0] din_s;

    assign pins_raw = {serial_port_select_n, host_addr0, host_read_n, host_write_n,
                       clear_to_send_n, serial_rx, host_data_in};

    // Two flops per pin; only the second stage is read by logic
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= {6'h3f, 8'h00};
            sync2_q <= {6'h3f, 8'h00};
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    assign {cs_n_s, a0_s, rd_n_s, wr_n_s, cts_n_s, rx_s, din_s} = sync2_q;

    // ==================================================================
    // Host strobe tracking
    logic wr_prev_q, rd_prev_q, wr_sel_q, wr_a0_q, rd_sel_q, rd_a0_q;
    logic [7:0] wr_data_q;
    logic wr_end, rd_end, cmd_write, data_write, data_read_done;

    // Capture select, address and data while each strobe is low, act at
    // its trailing edge so write data has settled and read data stayed put
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
            wr_sel_q <= 1'b0;
            wr_a0_q <= 1'b0;
            wr_data_q <= 8'h00;
            rd_sel_q <= 1'b0;
            rd_a0_q <= 1'b0;
        end else begin
            wr_prev_q <= wr_n_s;
            rd_prev_q <= rd_n_s;
            if (!wr_n_s) begin
                wr_sel_q <= ~cs_n_s;
                wr_a0_q <= a0_s;
                wr_data_q <= din_s;
            end
            if (!rd_n_s) begin
                rd_sel_q <= ~cs_n_s;
                rd_a0_q <= a0_s;
            end
        end
    end

    assign wr_end = wr_n_s & ~wr_prev_q;
    assign rd_end = rd_n_s & ~rd_prev_q;
    assign cmd_write = wr_end & wr_sel_q & (wr_a0_q == ADDR_CTRL);
    assign data_write = wr_end & wr_sel_q & (wr_a0_q == ADDR_DATA);
    assign data_read_done = rd_end & rd_sel_q & (rd_a0_q == ADDR_DATA);

    // ==================================================================
    // Command register
    logic [7:0] cmd_q;
    msp_rate_t rate;
    msp_txc_t txc;
    logic soft_rst;

    // Master reset leaves the rate field at the reset code
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cmd_q <= CMD_RESET_VAL;
        end else if (cmd_write) begin
            cmd_q <= wr_data_q;
        end
    end

    assign rate = msp_rate_t'(cmd_q[CMD_RATE_HI:CMD_RATE_LO]);
    assign txc = msp_txc_t'(cmd_q[CMD_TXC_HI:CMD_TXC_LO]);
    assign soft_rst = (rate == RATE_RESET);

    // ==================================================================
    // Oversampling ticks
    logic tick;

    msp_baud u_baud (
        .clock(clock),
        .rstn(rstn),
        .rate(rate),
        .tick(tick)
    );

    // ==================================================================
    // Transmit buffer: host writes feed a two-entry queue ahead of the
    // shifter; a write while both entries are full is dropped
    msp_strm_if tx_in ();
    msp_strm_if tx_out ();

    assign tx_in.valid = data_write;
    assign tx_in.data = wr_data_q;

    msp_fifo2 u_txbuf (
        .clock(clock),
        .rstn(rstn),
        .flush(soft_rst),
        .in_s(tx_in.snk),
        .out_s(tx_out.src)
    );

    // ==================================================================
    // Transmit shifter
    msp_tx_st_t tx_st_q;
    logic [9:0] tx_shift_q;
    logic [3:0] tx_bits_q, tx_sub_q;
    logic tx_line_q, tx_take;

    // Shifter pulls a byte only when idle, the far end is ready and a tick
    // is due, so the start bit gets a full bit time; a stall backs the queue up
    assign tx_out.ready = (tx_st_q == TX_IDLE) & ~cts_n_s & ~soft_rst & tick;
    assign tx_take = tx_out.valid & tx_out.ready;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tx_st_q <= TX_IDLE;
            tx_shift_q <= 10'h3ff;
            tx_bits_q <= 4'h0;
            tx_sub_q <= 4'h0;
        end else if (soft_rst) begin
            tx_st_q <= TX_IDLE;
            tx_shift_q <= 10'h3ff;
            tx_bits_q <= 4'h0;
            tx_sub_q <= 4'h0;
        end else begin
            case (tx_st_q)
                TX_IDLE: begin
                    if (tx_take) begin
                        tx_shift_q <= {1'b1, tx_out.data, 1'b0};
                        tx_bits_q <= TX_FRAME_BITS;
                        tx_sub_q <= 4'h0;
                        tx_st_q <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (tick) begin
                        tx_sub_q <= tx_sub_q + 4'h1;
                        if (tx_sub_q == OVS_LAST) begin
                            tx_shift_q <= {1'b1, tx_shift_q[9:1]};
                            tx_bits_q <= tx_bits_q - 4'h1;
                            if (tx_bits_q == 4'h1) tx_st_q <= TX_IDLE;
                        end
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // Line driver: break forces space, otherwise idle mark or frame bit
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tx_line_q <= 1'b1;
        end else if (txc == TXC_BREAK) begin
            tx_line_q <= 1'b0;
        end else begin
            tx_line_q <= (tx_st_q == TX_SHIFT) ? tx_shift_q[0] : 1'b1;
        end
    end

    assign serial_tx = tx_line_q;

    // ==================================================================
    // Receiver
    msp_rx_st_t rx_st_q;
    logic [3:0] rx_sub_q;
    logic [2:0] rx_bit_q;
    logic [7:0] rx_shift_q;
    logic rx_done, rx_stop_bad;

    // Start edge is confirmed at mid-bit; each later bit is sampled a
    // full bit time after the previous sample
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rx_st_q <= RX_IDLE;
            rx_sub_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_shift_q <= 8'h00;
            rx_done <= 1'b0;
            rx_stop_bad <= 1'b0;
        end else if (soft_rst) begin
            rx_st_q <= RX_IDLE;
            rx_sub_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_done <= 1'b0;
            rx_stop_bad <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (tick) begin
                rx_sub_q <= rx_sub_q + 4'h1;
                case (rx_st_q)
                    RX_IDLE: begin
                        rx_sub_q <= 4'h0;
                        if (!rx_s) rx_st_q <= RX_START;
                    end
                    RX_START: begin
                        if (rx_sub_q == OVS_MID) begin
                            rx_sub_q <= 4'h0;
                            rx_bit_q <= 3'h0;
                            rx_st_q <= rx_s ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (rx_sub_q == OVS_LAST) begin
                            rx_shift_q <= {rx_s, rx_shift_q[7:1]};
                            rx_bit_q <= rx_bit_q + 3'h1;
                            if (rx_bit_q == DATA_LAST) rx_st_q <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (rx_sub_q == OVS_LAST) begin
                            rx_done <= 1'b1;
                            rx_stop_bad <= ~rx_s;
                            rx_st_q <= RX_IDLE;
                        end
                    end
                    default: rx_st_q <= RX_IDLE;
                endcase
            end
        end
    end

    // ==================================================================
    // Receive buffer and receive flags
    logic [7:0] rx_data_q;
    logic rbf_q, fe_q, ov_q;

    // Holding register; the framing flag travels with its character
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rx_data_q <= 8'h00;
            fe_q <= 1'b0;
        end else if (soft_rst) begin
            fe_q <= 1'b0;
        end else if (rx_done) begin
            rx_data_q <= rx_shift_q;
            fe_q <= rx_stop_bad;
        end
    end

    // A character landing in the same cycle as a read keeps the flag set
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rbf_q <= 1'b0;
        end else if (soft_rst) begin
            rbf_q <= 1'b0;
        end else if (rx_done) begin
            rbf_q <= 1'b1;
        end else if (data_read_done) begin
            rbf_q <= 1'b0;
        end
    end

    // Overrun only when the old character was still unread at arrival
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ov_q <= 1'b0;
        end else if (soft_rst) begin
            ov_q <= 1'b0;
        end else if (rx_done && rbf_q && !data_read_done) begin
            ov_q <= 1'b1;
        end else if (data_read_done) begin
            ov_q <= 1'b0;
        end
    end

    // ==================================================================
    // Transmit status, modem lines and interrupt
    logic tx_empty_flag, irq_q, rts_n_q;

    // Empty means every written byte has reached the shifter, clear-to-send is low and the port is not in soft reset
    assign tx_empty_flag = ~tx_out.valid & ~cts_n_s & ~soft_rst;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
            rts_n_q <= 1'b1;
        end else begin
            irq_q <= (cmd_q[CMD_RIE] & (rbf_q | ov_q))
                   | ((txc == TXC_RTS_IRQ) & tx_empty_flag);
            rts_n_q <= (txc == TXC_NORTS);
        end
    end

    assign irq_n = ~irq_q;
    assign request_to_send_n = rts_n_q;

    // ==================================================================
    // Host read path
    logic [7:0] status;

    always_comb begin
        status = 8'h00;
        status[ST_RBF] = rbf_q;
        status[ST_TBE] = tx_empty_flag;
        status[ST_CTS] = cts_n_s;
        status[ST_FE] = fe_q;
        status[ST_OV] = ov_q;
        status[ST_IRQ] = irq_q;
    end

    // Drive the bus only during a selected read; data comes from flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            host_data_out <= 8'h00;
            host_data_oe_n <= 1'b1;
        end else begin
            host_data_oe_n <= ~(~rd_n_s & ~cs_n_s);
            if (!rd_n_s && !cs_n_s) begin
                host_data_out <= (a0_s == ADDR_DATA) ? rx_data_q : status;
            end
        end
    end

endmodule

//--- dv/msp_serial_port_props.sv
// Concurrent checks on the pins of the MIDI serial port.
// Assumes the bench holds clear-to-send steady through every frame.
`timescale 1ns/1ps
module msp_serial_port_props
    import msp_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic serial_port_select_n,
    input wire logic host_addr0,
    input wire logic host_read_n,
    input wire logic host_write_n,
    input wire logic [7:0] host_data_in,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe_n,
    input wire logic irq_n,
    input wire logic clear_to_send_n,
    input wire logic request_to_send_n,
    input wire logic serial_rx,
    input wire logic serial_tx
);
    localparam int BIT_MIN = 16 * DIV_FAST - 2;
    logic [3:0] wr_age_q;
    logic [3:0] cts_age_q;
    logic [15:0] low_run_q;

    // ==================================================================
    // Ages of pin events; saturating so long idles never wrap
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_age_q <= 4'hf;
            cts_age_q <= 4'h0;
            low_run_q <= 16'h0000;
        end else begin
            wr_age_q <= !host_write_n ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hf};
            cts_age_q <= $changed(clear_to_send_n) ? 4'h0 : cts_age_q + {3'h0, cts_age_q != 4'hf};
            low_run_q <= serial_tx ? 16'h0000 : low_run_q + {15'h0, low_run_q != 16'hffff};
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    // ==================================================================
    // Host read path
    property p_oe_on;
        (!host_read_n && !serial_port_select_n) [*4] |=> !host_data_oe_n;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("read not answered");
    property p_oe_off_rd;
        host_read_n [*4] |=> host_data_oe_n;
    endproperty
    a_oe_off_rd: assert property (p_oe_off_rd) else $error("bus held after read");
    property p_oe_off_sel;
        serial_port_select_n [*4] |=> host_data_oe_n;
    endproperty
    a_oe_off_sel: assert property (p_oe_off_sel) else $error("bus driven unselected");
    sequence s_stat_rd;
        !host_data_oe_n && !host_addr0 && !$past(host_addr0, 3) && !$past(host_addr0, 4);
    endsequence
    property p_stat_zero;
        s_stat_rd |-> !host_data_out[2] && !host_data_out[6];
    endproperty
    a_stat_zero: assert property (p_stat_zero) else $error("unused status bit set");
    property p_stat_cts;
        s_stat_rd |-> host_data_out[ST_CTS] == $past(clear_to_send_n, 3);
    endproperty
    a_stat_cts: assert property (p_stat_cts) else $error("status cts wrong");
    property p_stat_irq;
        s_stat_rd |-> host_data_out[ST_IRQ] == !$past(irq_n);
    endproperty
    a_stat_irq: assert property (p_stat_irq) else $error("status irq wrong");

    // ==================================================================
    // Serial line
    property p_tx_cts;
        $fell(serial_tx) && wr_age_q == 4'hf |-> !clear_to_send_n && cts_age_q >= 4'h2;
    endproperty
    a_tx_cts: assert property (p_tx_cts) else $error("sent while not clear");
    property p_tx_bit;
        $rose(serial_tx) && wr_age_q == 4'hf |-> low_run_q >= 16'(BIT_MIN);
    endproperty
    a_tx_bit: assert property (p_tx_bit) else $error("low pulse too short");
    property p_rst_idle;
        $rose(rstn) |-> (serial_tx && irq_n) [*3];
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");

    c_read: cover property ($fell(host_data_oe_n));
    c_tx: cover property ($fell(serial_tx));
    c_irq: cover property ($fell(irq_n));
endmodule

bind msp_serial_port msp_serial_port_props u_props (.clock, .rstn, .serial_port_select_n,
    .host_addr0, .host_read_n, .host_write_n, .host_data_in, .host_data_out, .host_data_oe_n,
    .irq_n, .clear_to_send_n, .request_to_send_n, .serial_rx, .serial_tx);

//--- dv/msp_far_dev.sv
// Far serial device: sends 8N1 frames and decodes what the port sends.
// Assumes one fixed bit time in clocks, set by the bench.
`timescale 1ns/1ps
module msp_far_dev #(
    parameter int BIT_CLKS = 2592
) (
    input wire logic clock,
    input wire logic serial_tx,
    output logic serial_rx,
    output logic clear_to_send_n
);
    logic [7:0] tx_byte, rx_b;
    logic tx_stop;
    int tx_cnt, start_len, cnt_l;

    initial begin
        serial_rx = 1'b1;
        clear_to_send_n = 1'b0;
    end

    // ==================================================================
    // Driving side; a bad stop level lets the bench force a framing fault
    task set_cts(input logic v);
        @(negedge clock);
        clear_to_send_n = v;
    endtask

    task send_byte(input logic [7:0] b, input logic stop);
        logic [9:0] frame;
        frame = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clock);
            serial_rx = frame[i];
            repeat (BIT_CLKS - 1) @(negedge clock);
        end
        @(negedge clock);
        serial_rx = 1'b1;
    endtask

    // ==================================================================
    // Decoder: start length measured, then mid-bit samples LSB first
    always begin
        @(negedge serial_tx);
        cnt_l = 0;
        while (serial_tx === 1'b0 && cnt_l < 2 * BIT_CLKS) begin
            @(posedge clock);
            cnt_l++;
        end
        start_len = cnt_l;
        repeat (BIT_CLKS / 2) @(posedge clock);
        for (int k = 0; k < 8; k++) begin
            rx_b[k] = serial_tx;
            repeat (BIT_CLKS) @(posedge clock);
        end
        tx_stop = serial_tx;
        tx_byte = rx_b;
        tx_cnt++;
    end
endmodule

//--- dv/msp_serial_port_tb.sv
// Self-checking bench for the serial port through its host pins.
// Assumes the far device model runs at the fastest rate.
`timescale 1ns/1ps
module msp_serial_port_tb;
    import msp_pkg::*;
    localparam int BIT_CLKS = 16 * DIV_FAST;
    logic clock, rstn, serial_port_select_n, host_addr0, host_read_n, host_write_n;
    logic [7:0] host_data_in, host_data_out, rd_v;
    logic host_data_oe_n, irq_n, clear_to_send_n, request_to_send_n, serial_rx, serial_tx;
    int error_cnt, num_checks, n;
    logic [7:0] tc_cmd [3] = '{8'h22, 8'h42, 8'h62};
    logic [2:0] tc_exp [3] = '{3'b001, 3'b111, 3'b010};

    msp_serial_port dut (.clock, .rstn, .serial_port_select_n, .host_addr0, .host_read_n,
        .host_write_n, .host_data_in, .host_data_out, .host_data_oe_n, .irq_n,
        .clear_to_send_n, .request_to_send_n, .serial_rx, .serial_tx);
    msp_far_dev #(.BIT_CLKS(BIT_CLKS)) far (.clock, .serial_tx, .serial_rx, .clear_to_send_n);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ==================================================================
    // Compare, host strobes and verdict
    task check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task final_report;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Write strobe held 4 clocks, read strobe 5, so the two-flop sync always sees them
    task bus_wr(input logic adr, input logic [7:0] d);
        @(negedge clock);
        serial_port_select_n = 1'b0;
        host_addr0 = adr;
        host_data_in = d;
        host_write_n = 1'b0;
        repeat (4) @(negedge clock);
        host_write_n = 1'b1;
        repeat (4) @(negedge clock);
        serial_port_select_n = 1'b1;
        repeat (3) @(negedge clock);
    endtask

    task rd_chk(input logic adr, input logic [7:0] mask, input logic [7:0] exp, input string what);
        @(negedge clock);
        serial_port_select_n = 1'b0;
        host_addr0 = adr;
        host_read_n = 1'b0;
        repeat (5) @(negedge clock);
        rd_v = host_data_out;
        check8({7'h0, host_data_oe_n}, 8'h00, "output enable");
        host_read_n = 1'b1;
        repeat (4) @(negedge clock);
        serial_port_select_n = 1'b1;
        repeat (3) @(negedge clock);
        check8(rd_v & mask, exp, what);
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        serial_port_select_n = 1'b1;
        host_addr0 = 1'b0;
        host_read_n = 1'b1;
        host_write_n = 1'b1;
        host_data_in = 8'h00;
        error_cnt = 0;
        num_checks = 0;
        repeat (4) @(negedge clock);
        rstn = 1'b1;
        repeat (2) @(negedge clock);
        rd_chk(ADDR_CTRL, 8'hff, 8'h00, "status after reset");
        far.set_cts(1'b1);
        bus_wr(ADDR_CTRL, 8'h82);
        rd_chk(ADDR_CTRL, 8'hff, 8'h08, "status cts high");
        bus_wr(ADDR_DATA, 8'ha5);
        rd_chk(ADDR_CTRL, 8'hff, 8'h08, "status queued");
        n = far.tx_cnt;
        fork
            far.send_byte(8'h3c, 1'b1);
            far.set_cts(1'b0);
        join
        for (int i = 0; i < 4 * BIT_CLKS && far.tx_cnt == n; i++) @(negedge clock);
        check8(8'(far.tx_cnt - n), 8'h01, "frame count");
        check8(far.tx_byte, 8'ha5, "sent byte");
        check8({7'h0, far.tx_stop}, 8'h01, "stop level");
        check8({7'h0, far.start_len inside {[BIT_CLKS-2:BIT_CLKS+2]}}, 8'h01, "bit time");
        rd_chk(ADDR_CTRL, 8'hff, 8'h83, "status rx full");
        check8({7'h0, irq_n}, 8'h00, "irq pin");
        rd_chk(ADDR_DATA, 8'hff, 8'h3c, "rx data");
        rd_chk(ADDR_CTRL, 8'hff, 8'h02, "status read clear");
        far.send_byte(8'h11, 1'b1);
        far.send_byte(8'h22, 1'b0);
        repeat (20) @(negedge clock);
        rd_chk(ADDR_CTRL, 8'hff, 8'hb3, "status overrun");
        rd_chk(ADDR_DATA, 8'hff, 8'h22, "newest data");
        rd_chk(ADDR_CTRL, 8'hef, 8'h02, "overrun cleared");
        for (int i = 0; i < 3; i++) begin
            bus_wr(ADDR_CTRL, tc_cmd[i]);
            repeat (8) @(negedge clock);
            check8({5'h0, request_to_send_n, irq_n, serial_tx}, {5'h0, tc_exp[i]}, "tx ctl");
        end
        bus_wr(ADDR_CTRL, 8'h03);
        rd_chk(ADDR_CTRL, 8'hff, 8'h00, "soft reset status");
        check8({7'h0, serial_tx}, 8'h01, "line idle");
        final_report();
    end
endmodule
